// [rtl/fbm_pkg.sv]
// Purpose: constants for the flash bus mode host controller
// Assumes: 100 MHz clock, 10 ns period
// Notes:   command codes and unlock addresses of the flash command set
package fbm_pkg;
    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS   = 10;
    localparam int WAKE_NS         = 500;
    localparam int WAKE_CYC        = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACCESS_NS       = 90;
    localparam int ACCESS_CYC      = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_NS        = 50;
    localparam int PULSE_CYC       = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ==========================================================
    // command set
    localparam logic [19:0] UNLOCK_ADDR_A = 20'h0_0555;
    localparam logic [19:0] UNLOCK_ADDR_B = 20'h0_02AA;
    localparam logic [7:0]  UNLOCK_DATA_A = 8'hAA;
    localparam logic [7:0]  UNLOCK_DATA_B = 8'h55;
    localparam logic [7:0]  CMD_RESET     = 8'hF0;
    localparam logic [7:0]  CMD_IDENT     = 8'h90;
    // ==========================================================
    // identifier mode addresses
    localparam logic [19:0] ID_MAKER_ADDR = 20'h0_0000;
    localparam logic [19:0] ID_PART_ADDR  = 20'h0_0001;
    localparam logic [19:0] ID_PROT_ADDR  = 20'h0_0002;
    localparam int          GROUP_LSB     = 17;
    // ==========================================================
    // host operations
    typedef enum logic [2:0] {
        OP_READ, OP_WRITE, OP_ID_CMD, OP_EXIT_ID, OP_ID_READ, OP_PROT_SET, OP_PROT_VERIFY, OP_STANDBY
    } fbm_op_e;
endpackage : fbm_pkg

// [rtl/fbm_host.sv]
// Purpose: host controller driving a parallel flash through its pins
// Assumes: flash data pins synchronised here; elevated voltages are enable outputs
// Notes:   one operation at a time, req/ack handshake
`timescale 1ns/1ns
`default_nettype none
module fbm_host #(
    parameter int ADDR_W = 20,
    parameter int DATA_W = 8
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              clkEn,
    input  wire logic              reqValid,
    output logic                   reqReady,
    input  wire fbm_pkg::fbm_op_e  reqOp,
    input  wire logic [ADDR_W-1:0] reqAddr,
    input  wire logic [DATA_W-1:0] reqData,
    input  wire logic              tempUnprotect,
    output logic                   respValid,
    output logic [DATA_W-1:0]      respData,
    output logic                   respParityOk,
    output logic [ADDR_W-1:0]      flashAddr,
    output logic [DATA_W-1:0]      flashDataOut,
    output logic                   flashDataOe,
    input  wire logic [DATA_W-1:0] flashDataIn,
    output logic                   selectN,
    output logic                   gateN,
    output logic                   strobeN,
    output logic                   resetN,
    output logic                   idVoltOnAddrNine,
    output logic                   idVoltOnGate,
    output logic                   idVoltOnReset
);
    // ==========================================================
    // state and registers
    typedef enum logic [2:0] {
        S_WAKE, S_IDLE, S_SETUP, S_PULSE, S_HOLD, S_DONE
    } fbm_state_e;

    localparam int CNT_W = 8;

    fbm_state_e          state_r, state_nxt;
    logic [CNT_W-1:0]    cnt_r;
    logic [1:0]          step_r;
    fbm_pkg::fbm_op_e    op_r;
    logic [ADDR_W-1:0]   addr_r, useAddr;
    logic [DATA_W-1:0]   data_r, useData;
    logic [DATA_W-1:0]   rdSync1_r, rdSync2_r;
    logic [DATA_W-1:0]   respData_r;
    logic                respValid_r;
    logic [ADDR_W-1:0]   flashAddr_r;
    logic [DATA_W-1:0]   flashDataOut_r;
    logic                oe_r, sel_r, gate_r, strobe_r, rstPin_r, nine_r, gateHv_r, rstHv_r;

    // ==========================================================
    // operation decode
    wire isRead     = (op_r == fbm_pkg::OP_READ) || (op_r == fbm_pkg::OP_ID_READ) ||
                      (op_r == fbm_pkg::OP_PROT_VERIFY);
    wire isMulti    = (op_r == fbm_pkg::OP_ID_CMD) || (op_r == fbm_pkg::OP_EXIT_ID);
    wire lastStep   = !isMulti || (step_r == 2'd2);
    wire hvNine     = (op_r == fbm_pkg::OP_ID_READ) || (op_r == fbm_pkg::OP_PROT_SET) ||
                      (op_r == fbm_pkg::OP_PROT_VERIFY);
    wire [CNT_W-1:0] phaseLen = isRead ? CNT_W'(fbm_pkg::ACCESS_CYC) : CNT_W'(fbm_pkg::PULSE_CYC);
    wire cntDone    = (cnt_r == '0);
    // standby: pin held low for one wake span, then released for another
    wire inResetPhase = (op_r == fbm_pkg::OP_STANDBY) && (step_r == 2'd0);
    wire standbyLow   = (state_r == S_WAKE) && inResetPhase && !cntDone;

    // unlock sequence address and data per step
    always_comb begin
        useAddr = addr_r;
        useData = data_r;
        if (isMulti) begin
            unique case (step_r)
                2'd0: begin
                    useAddr = fbm_pkg::UNLOCK_ADDR_A;
                    useData = fbm_pkg::UNLOCK_DATA_A;
                end
                2'd1: begin
                    useAddr = fbm_pkg::UNLOCK_ADDR_B;
                    useData = fbm_pkg::UNLOCK_DATA_B;
                end
                default: begin
                    useAddr = fbm_pkg::UNLOCK_ADDR_A;
                    useData = (op_r == fbm_pkg::OP_ID_CMD) ? fbm_pkg::CMD_IDENT : fbm_pkg::CMD_RESET;
                end
            endcase
        end else if (op_r == fbm_pkg::OP_PROT_VERIFY) begin
            useAddr = addr_r;
            useAddr[6] = 1'b0;
            useAddr[1] = 1'b1;
            useAddr[0] = 1'b0;
        end else if (op_r == fbm_pkg::OP_ID_READ) begin
            useAddr = addr_r;
            useAddr[1] = 1'b0;
        end
    end

    // next state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            S_WAKE:  if (cntDone && !inResetPhase) state_nxt = S_IDLE;
            S_IDLE:  if (reqValid) state_nxt = (reqOp == fbm_pkg::OP_STANDBY) ? S_WAKE : S_SETUP;
            S_SETUP: state_nxt = S_PULSE;
            S_PULSE: if (cntDone) state_nxt = S_HOLD;
            S_HOLD:  state_nxt = lastStep ? S_DONE : S_SETUP;
            S_DONE:  state_nxt = S_IDLE;
        endcase
    end

    // ==========================================================
    // sequencer
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= S_WAKE;
            cnt_r   <= CNT_W'(fbm_pkg::WAKE_CYC);
            step_r  <= 2'd0;
            op_r    <= fbm_pkg::OP_READ;
            addr_r  <= '0;
            data_r  <= '0;
        end else if (clkEn) begin
            state_r <= state_nxt;
            if (state_r == S_IDLE && reqValid) begin
                op_r   <= reqOp;
                addr_r <= reqAddr;
                data_r <= reqData;
                step_r <= 2'd0;
                if (reqOp == fbm_pkg::OP_STANDBY)
                    cnt_r <= CNT_W'(fbm_pkg::WAKE_CYC);
            end
            if (state_r == S_SETUP)
                cnt_r <= phaseLen - 1'b1;
            else if (!cntDone && state_r != S_IDLE)
                cnt_r <= cnt_r - 1'b1;
            if (state_r == S_HOLD && !lastStep)
                step_r <= step_r + 2'd1;
            // end of the low phase: reload for the wake wait
            if (state_r == S_WAKE && cntDone && inResetPhase) begin
                cnt_r  <= CNT_W'(fbm_pkg::WAKE_CYC);
                step_r <= 2'd1;
            end
        end
    end

    // pin drive: setup holds address, gate low for reads, strobe high; pulse asserts strobe for writes only
    always_ff @(posedge clk) begin
        if (rst) begin
            flashAddr_r    <= '0;
            flashDataOut_r <= '0;
            oe_r     <= 1'b0;
            sel_r    <= 1'b1;
            gate_r   <= 1'b1;
            strobe_r <= 1'b1;
            rstPin_r <= 1'b0;
            nine_r   <= 1'b0;
            gateHv_r <= 1'b0;
            rstHv_r  <= 1'b0;
        end else if (clkEn) begin
            rstPin_r <= !standbyLow;
            rstHv_r  <= tempUnprotect;
            if (state_r == S_SETUP) begin
                flashAddr_r    <= useAddr;
                flashDataOut_r <= useData;
                sel_r    <= 1'b0;
                gate_r   <= !isRead;
                oe_r     <= !isRead;
                nine_r   <= hvNine;
                gateHv_r <= (op_r == fbm_pkg::OP_PROT_SET);
                strobe_r <= 1'b1;
            end else if (state_r == S_PULSE) begin
                strobe_r <= isRead;
            end else if (state_r == S_HOLD) begin
                strobe_r <= 1'b1;
            end else if (state_r == S_DONE || state_r == S_IDLE) begin
                sel_r    <= 1'b1;
                gate_r   <= 1'b1;
                oe_r     <= 1'b0;
                nine_r   <= 1'b0;
                gateHv_r <= 1'b0;
            end
        end
    end

    // ==========================================================
    // read data capture through two flops
    always_ff @(posedge clk) begin
        if (rst) begin
            rdSync1_r   <= '0;
            rdSync2_r   <= '0;
            respData_r  <= '0;
            respValid_r <= 1'b0;
        end else if (clkEn) begin
            rdSync1_r   <= flashDataIn;
            rdSync2_r   <= rdSync1_r;
            respValid_r <= (state_r == S_DONE);
            if (state_r == S_HOLD && isRead)
                respData_r <= rdSync2_r;
        end
    end

    // ==========================================================
    // outputs
    assign reqReady         = (state_r == S_IDLE) && clkEn;
    assign respValid        = respValid_r;
    assign respData         = respData_r;
    assign respParityOk     = ^respData_r;
    assign flashAddr        = flashAddr_r;
    assign flashDataOut     = flashDataOut_r;
    assign flashDataOe      = oe_r;
    assign selectN          = sel_r;
    assign gateN            = gate_r;
    assign strobeN          = strobe_r;
    assign resetN           = rstPin_r;
    assign idVoltOnAddrNine = nine_r;
    assign idVoltOnGate     = gateHv_r;
    assign idVoltOnReset    = rstHv_r;
endmodule // fbm_host
`default_nettype wire

// [sim/fbm_host_assertions.sv]
// Purpose: port assertions for the flash host controller
// Assumes: one clock, sync reset, clkEn held high
// Notes:   bound from the bench top file
`timescale 1ns/1ns
`default_nettype none
module fbm_host_assertions (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        reqValid,
    input wire logic        reqReady,
    input wire logic        respValid,
    input wire logic [7:0]  respData,
    input wire logic        respParityOk,
    input wire logic [19:0] flashAddr,
    input wire logic        flashDataOe,
    input wire logic        selectN,
    input wire logic        gateN,
    input wire logic        strobeN,
    input wire logic        resetN,
    input wire logic        tempUnprotect,
    input wire logic        idVoltOnGate,
    input wire logic        idVoltOnReset
);
    localparam int WAKE = fbm_pkg::WAKE_CYC;
    logic [7:0] awake_r;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ====
    // cycles since the flash left reset
    always_ff @(posedge clk) begin
        if (rst || !resetN) awake_r <= 8'h00;
        else if (awake_r != 8'hFF) awake_r <= awake_r + 8'h01;
    end
    // ====
    // pin rules
    wake_wait_a: assert property (!selectN |-> int'(awake_r) >= WAKE)
        else $error("select before wake time");
    reset_idle_a: assert property (!resetN |-> selectN && strobeN)
        else $error("bus active in reset");
    write_gate_a: assert property (!strobeN && !idVoltOnGate |-> gateN && !selectN)
        else $error("bad write pin levels");
    no_clash_a: assert property (!gateN |-> !flashDataOe)
        else $error("host drives data while gate low");
    read_sel_a: assert property ($fell(gateN) && !idVoltOnGate |-> !selectN && strobeN)
        else $error("read without select");
    addr_hold_a: assert property (!strobeN && !$past(strobeN) |-> $stable(flashAddr))
        else $error("address moved in strobe");
    parity_ok_a: assert property (respValid |-> respParityOk == ^respData)
        else $error("parity flag wrong");
    unprot_on_a: assert property ($rose(tempUnprotect) |=> idVoltOnReset)
        else $error("unprotect not applied");
    resp_idle_a: assert property (respValid |-> selectN && gateN && strobeN)
        else $error("pins busy at response");
    cover property (respValid && respData == 8'h01);
    cover property (!strobeN && idVoltOnGate);
    cover property (reqValid && reqReady);
endmodule // fbm_host_assertions
`default_nettype wire

// [sim/fbm_flash_model.sv]
// Purpose: behavioural parallel flash for the host bench
// Assumes: array byte is low address xor 5A
// Notes:   id codes are arbitrary, odd parity
`timescale 1ns/1ns
`default_nettype none
module fbm_flash_model #(
    parameter logic [7:0] MAKER  = 8'h8A, // arbitrary value
    parameter logic [7:0] PART   = 8'h13, // arbitrary value
    parameter int         ACC_NS = 70
) (
    input  wire logic [19:0] addr,
    input  wire logic [7:0]  dataIn,
    input  wire logic        selectN,
    input  wire logic        gateN,
    input  wire logic        strobeN,
    input  wire logic        resetN,
    input  wire logic        nineHigh,
    input  wire logic        gateHigh,
    output wire logic [7:0]  dataOut
);
    logic [7:0]  prot_r = 8'h00;
    logic [1:0]  step_r = 2'h0; // kept while deselected
    logic        idMode_r = 1'b0;
    logic [19:0] wa_r;
    logic [7:0]  last_r = 8'h00;
    wire  [7:0]  rd;
    wire         drv = !selectN && !gateN && resetN && !gateHigh;
    // address at the later falling edge
    always @(negedge strobeN or negedge selectN) if (!strobeN && !selectN) wa_r = addr;
    // data at rising strobe, command decoder
    always @(posedge strobeN) if (!selectN && resetN) begin
        if (nineHigh && gateHigh) prot_r[wa_r[19:17]] = 1'b1;
        else if (step_r == 2'h0 && wa_r[10:0] == 11'h555 && dataIn == 8'hAA) step_r = 2'h1;
        else if (step_r == 2'h1 && wa_r[10:0] == 11'h2AA && dataIn == 8'h55) step_r = 2'h2;
        else begin
            idMode_r = step_r == 2'h2 && wa_r[10:0] == 11'h555 && dataIn == 8'h90;
            step_r = 2'h0;
        end
    end
    // array, identifier or group status byte
    assign rd = !(idMode_r || nineHigh) ? (addr[7:0] ^ 8'h5A)
              : !addr[1] ? (addr[0] ? PART : MAKER)
              : (!addr[6] && !addr[0]) ? {7'h00, prot_r[addr[19:17]]} : 8'h00;
    // released bus shows inverse of last byte
    always @(rd or drv) if (drv) last_r = rd;
    assign #(ACC_NS) dataOut = drv ? rd : ~last_r;
endmodule // fbm_flash_model
`default_nettype wire

// [sim/fbm_host_bench.sv]
// Purpose: self-checking bench for fbm_host
// Assumes: flash model on the far side
// Notes:   table of operations, then hand tests
`timescale 1ns/1ns
`default_nettype none
module fbm_host_bench;
    typedef struct {fbm_pkg::fbm_op_e op; logic [19:0] a; logic [7:0] d; logic [7:0] e; bit c;} fbm_row_s;
    logic clk = 1'b0, rst = 1'b1, reqValid = 1'b0, tempUnprotect = 1'b0, clkEn = 1'b1;
    fbm_pkg::fbm_op_e reqOp = fbm_pkg::OP_READ;
    logic [19:0] reqAddr = 20'h0_0000, flashAddr;
    logic [7:0]  reqData = 8'h00, respData, flashDataOut, devData;
    logic reqReady, respValid, respParityOk, flashDataOe, selectN, gateN, strobeN, resetN;
    logic idVoltOnAddrNine, idVoltOnGate, idVoltOnReset;
    wire logic [7:0] busData = flashDataOe ? flashDataOut : devData;
    int nFail = 0, nChecks = 0;
    fbm_row_s rows [12] = '{
        '{fbm_pkg::OP_READ, 20'h0_0123, 8'h00, 8'h79, 1'b1}, '{fbm_pkg::OP_ID_READ, 20'h0_0000, 8'h00, 8'h8A, 1'b1},
        '{fbm_pkg::OP_ID_READ, 20'h0_0001, 8'h00, 8'h13, 1'b1}, '{fbm_pkg::OP_PROT_VERIFY, 20'h6_0000, 8'h00, 8'h00, 1'b1},
        '{fbm_pkg::OP_PROT_SET, 20'h6_0000, 8'h00, 8'h00, 1'b0}, '{fbm_pkg::OP_PROT_VERIFY, 20'h6_0000, 8'h00, 8'h01, 1'b1},
        '{fbm_pkg::OP_ID_CMD, 20'h0_0000, 8'h00, 8'h00, 1'b0}, '{fbm_pkg::OP_READ, 20'h6_0002, 8'h00, 8'h01, 1'b1},
        '{fbm_pkg::OP_EXIT_ID, 20'h0_0000, 8'h00, 8'h00, 1'b0}, '{fbm_pkg::OP_READ, 20'h6_0002, 8'h00, 8'h58, 1'b1},
        '{fbm_pkg::OP_ID_CMD, 20'h0_0000, 8'h00, 8'h00, 1'b0}, '{fbm_pkg::OP_WRITE, 20'h0_0555, 8'h12, 8'h00, 1'b0}};
    fbm_host dut (.clk, .rst, .clkEn, .reqValid, .reqReady, .reqOp, .reqAddr, .reqData, .tempUnprotect,
        .respValid, .respData, .respParityOk, .flashAddr, .flashDataOut, .flashDataOe, .flashDataIn(busData),
        .selectN, .gateN, .strobeN, .resetN, .idVoltOnAddrNine, .idVoltOnGate, .idVoltOnReset);
    fbm_flash_model flash (.addr(flashAddr), .dataIn(flashDataOut), .selectN, .gateN, .strobeN, .resetN,
        .nineHigh(idVoltOnAddrNine), .gateHigh(idVoltOnGate), .dataOut(devData));
    // ====
    // clock and watchdog
    initial forever #5 clk = ~clk;
    initial begin
        #100000;
        nFail++;
        report_and_stop();
    end
    // ====
    // tasks
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        nChecks++;
        if (seen !== exp) begin
            nFail++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic issue(input fbm_pkg::fbm_op_e op, input logic [19:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(negedge clk);
        reqOp = op;
        reqAddr = a;
        reqData = d;
        reqValid = 1'b1;
        while (reqReady !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        reqValid = 1'b0;
        if (n == 300) check("ready wait", 8'h00, 8'h01);
    endtask
    task automatic answer();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (respValid !== 1'b1 && n < 300);
        if (n == 300) check("response wait", 8'h00, 8'h01);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", nChecks, nFail);
        if (nFail == 0 && nChecks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // ====
    // main sequence
    initial begin
        repeat (4) @(negedge clk);
        check("pins in reset", {6'h00, resetN, selectN}, 8'h01);
        rst = 1'b0;
        foreach (rows[i]) begin
            issue(rows[i].op, rows[i].a, rows[i].d);
            answer();
            if (rows[i].c) check("read byte", respData, rows[i].e);
            if (rows[i].op == fbm_pkg::OP_ID_READ) check("id parity", {7'h00, respParityOk}, 8'h01);
        end
        issue(fbm_pkg::OP_READ, 20'h0_0000, 8'h00);
        answer();
        check("after bad write", respData, 8'h5A);
        issue(fbm_pkg::OP_STANDBY, 20'h0_0000, 8'h00);
        @(negedge clk);
        check("standby reset pin", {7'h00, resetN}, 8'h00);
        issue(fbm_pkg::OP_READ, 20'h0_00FF, 8'h00);
        answer();
        check("after standby", respData, 8'hA5);
        @(negedge clk);
        check("ready when idle", {7'h00, reqReady}, 8'h01);
        clkEn = 1'b0;
        @(negedge clk);
        check("ready when frozen", {7'h00, reqReady}, 8'h00);
        clkEn = 1'b1;
        tempUnprotect = 1'b1;
        repeat (2) @(negedge clk);
        check("unprotect pin", {7'h00, idVoltOnReset}, 8'h01);
        tempUnprotect = 1'b0;
        report_and_stop();
    end
endmodule // fbm_host_bench
bind fbm_host fbm_host_assertions chk (.clk, .rst, .reqValid, .reqReady, .respValid, .respData, .respParityOk,
    .flashAddr, .flashDataOe, .selectN, .gateN, .strobeN, .resetN, .tempUnprotect, .idVoltOnGate, .idVoltOnReset);
`default_nettype wire
